//--- shared/pcr_regs.svh
// Constants for the pipelined core: data-memory locations, opcode
// prefixes, reset values and pipeline timing counts.
// Assumes inclusion by bare name from the package and the core.
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

// Global bank locations (4-bit index within the global bank)
`define PCR_ADDR_DEREF 4'h0
`define PCR_ADDR_CNTW 4'h1
`define PCR_ADDR_PCL 4'h2
`define PCR_ADDR_STATUS 4'h3
`define PCR_ADDR_BANKPTR 4'h4
`define PCR_ADDR_PORTA 4'h5

// Operand field: bit 4 picks banked page over the global bank
`define PCR_FR_BANK_BIT 4

// Status page-select bits that extend jumps and PC writes
`define PCR_STATUS_PA_HI 6
`define PCR_STATUS_PA_LO 5

// Register-operand opcodes, word[11:5]
`define PCR_OP_MOVWF 7'h01
`define PCR_OP_DEC 7'h07
`define PCR_OP_XORWF 7'h0C
`define PCR_OP_XORFW 7'h0D
`define PCR_OP_MOVFW 7'h10
`define PCR_OP_TEST 7'h11
`define PCR_OP_SWAP 7'h1D
// Bit and literal opcodes, word[11:8]
`define PCR_OP_BCLR 4'h4
`define PCR_OP_BSET 4'h5
`define PCR_OP_MOVLW 4'hC
`define PCR_OP_XORLW 4'hF
// Jump opcode, word[11:9]
`define PCR_OP_JMP 3'h5

// Reset values
`define PCR_RST_PC 11'h000
`define PCR_RST_BYTE 8'h00
`define PCR_RST_HOLD 2'h0

// Cycles a program-counter change adds to its instruction
`define PCR_FLUSH_PENALTY 3
// Refill alone costs two; the rest is held fetch bubbles
`define PCR_FLUSH_HOLD 2'(`PCR_FLUSH_PENALTY - 2)
// Cycles a port write is forwarded to read-modify-write reads
`define PCR_WB_HOLD 2'h3

`endif

//--- shared/pcr_pkg.sv
// Types shared by the core and its port slices.
// Assumes pcr_regs.svh is on the include path.
`include "pcr_regs.svh"

package pcr_pkg;

    // Operation classes after decode; zero is the bubble
    typedef enum logic [3:0] {
        OP_NOP,
        OP_MOVWF,
        OP_MOVFW,
        OP_DEC,
        OP_XORFW,
        OP_XORWF,
        OP_TEST,
        OP_SWAP,
        OP_BCLR,
        OP_BSET,
        OP_MOVLW,
        OP_XORLW,
        OP_JMP
    } pcr_op_t;

    // Word held in the decode stage
    typedef struct packed {
        logic valid;
        logic [11:0] word;
    } pcr_fetch_t;

    // Decoded instruction held in the execute stage
    typedef struct packed {
        logic valid;
        pcr_op_t op;
        logic [4:0] fr;
        logic [2:0] bitn;
        logic [8:0] lit;
    } pcr_dec_t;

    // Resolved data-memory location
    typedef struct packed {
        logic is_bank;
        logic blocked;
        logic [7:0] ram_idx;
        logic [3:0] gidx;
    } pcr_loc_t;

    // One port's pin drive
    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe_n;
    } pcr_pins_t;

endpackage : pcr_pkg

//--- verilog/pcr_port.sv
// One I/O port slice: output latch, pin synchroniser and write-back.
// Assumes pin levels are asynchronous; drive enables come from clk.
`include "pcr_regs.svh"

module pcr_port
#(
    parameter bit PRESENT = 1'b1 // Port fitted on this package
)
(
    input wire logic clk, // Core clock
    input wire logic arst_n, // Async reset, active low
    input wire logic [7:0] pin_in, // Raw pin levels
    input wire logic [7:0] drive_en, // High where the pin is driven
    input wire logic wr_en, // Latch write strobe
    input wire logic [7:0] wr_data, // Latch write data
    output logic [7:0] pin_val, // Synchronised pin levels
    output logic [7:0] rmw_val, // Source for read-modify-write
    output pcr_pkg::pcr_pins_t pins // Pin drive
);
    import pcr_pkg::*;

    logic [7:0] sync1_ff;
    logic [7:0] sync2_ff;
    logic [7:0] latch_ff;
    logic [7:0] drive_ff;
    logic [1:0] wb_cnt_ff;

    ////////////////////////////////////////////////////////////////////
    // Two-stage pin synchroniser; only sync2 is looked at
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_ff <= `PCR_RST_BYTE;
            sync2_ff <= `PCR_RST_BYTE;
        end
        else
        begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
        end
    end

    // Output latch and registered drive enables
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            latch_ff <= `PCR_RST_BYTE;
            drive_ff <= `PCR_RST_BYTE;
        end
        else
        begin
            if (wr_en)
                latch_ff <= wr_data;
            drive_ff <= drive_en & {8{PRESENT}};
        end
    end

    // Pending window covers latch-to-pin plus synchroniser delay
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wb_cnt_ff <= `PCR_RST_HOLD;
        else if (wr_en)
            wb_cnt_ff <= `PCR_WB_HOLD;
        else if (wb_cnt_ff != `PCR_RST_HOLD)
            wb_cnt_ff <= wb_cnt_ff - 2'h1;
    end

    ////////////////////////////////////////////////////////////////////
    // Plain reads see the pins, even on driven bits
    assign pin_val = sync2_ff;
    // Back-to-back modify sees the pending latch on driven bits
    assign rmw_val = (wb_cnt_ff != `PCR_RST_HOLD)
        ? ((latch_ff & drive_ff) | (sync2_ff & ~drive_ff))
        : sync2_ff;
    assign pins.dout = latch_ff;
    assign pins.oe_n = ~drive_ff;

endmodule : pcr_port

//--- verilog/pcr_core.sv
// Three-stage instruction pipeline with the banked data-memory map.
// Assumes a program memory read combinationally on clk, and port pins
// arriving asynchronously; port direction is set from outside.
//
// Notes on behaviour
// - fetch, decode and execute overlap on three successive clocks.
// - with the pipeline full, one instruction completes every clock.
// - a program-counter change turns fetched and decoded words into nops.
// - a program-counter change costs its instruction three more cycles.
// - back-to-back modify on one port uses the pending written value on driven bits.
// - reading a port returns pin levels, not the output latch.
// - operand bit 4 picks global bank (clear) or current banked page (set).
// - one global bank plus eight or sixteen banks of sixteen bytes.
// - globals: deref, counter/working, PC low, status, bank pointer, ports.
// - the deref location has no storage and acts on the pointed register.
// - locations of unfitted ports C, D, E act as plain RAM.
// - in the large variant bank 0 is not reachable by direct operands.
// - location 1 shows the counter when the select is set, else working.
// - locations 0x01 to 0x0F ignore the bank pointer.
`include "pcr_regs.svh"

module pcr_core
#(
    parameter bit LARGE_VARIANT = 1'b1, // Sixteen banks, else eight
    parameter int PORTS_PRESENT = 5 // Ports fitted: 2, 3 or 5
)
(
    input wire logic clk, // Core clock, 250 MHz
    input wire logic arst_n, // Async reset, active low
    output logic [10:0] prog_addr, // Program memory address
    input wire logic [11:0] prog_word, // Program memory word
    input wire logic counter_alias_select, // Location 1 shows counter
    input wire logic [4:0][7:0] port_drive_en, // Per-pin drive enable
    input wire logic [4:0][7:0] port_pin_in, // Raw pin levels
    output pcr_pkg::pcr_pins_t [4:0] port_pins, // Pin drive, ports A-E
    output logic retire // Instruction completed last cycle
);
    import pcr_pkg::*;

    localparam logic [3:0] PORT_END =
        4'(`PCR_ADDR_PORTA + PORTS_PRESENT);

    logic [10:0] pc_ff;
    pcr_fetch_t dec_ff;
    pcr_dec_t ex_ff;
    logic [1:0] hold_ff;
    logic retire_ff;
    logic [7:0] w_ff;
    logic [7:0] tick_ff;
    logic [7:0] status_ff;
    logic [7:0] bptr_ff;
    logic [7:0] glob_ram_ff [16];
    logic [7:0] bank_ram_ff [256];

    pcr_loc_t loc;
    logic indirect;
    logic rmw;
    logic [7:0] rd_val;
    logic [7:0] bmask;
    logic [7:0] res;
    logic wr_f;
    logic wr_w;
    logic [7:0] nxt_w;
    logic f_wr;
    logic g_wr;
    logic pc_wr;
    logic jump_take;
    logic [10:0] jump_target;
    logic [4:0] port_wr;
    logic [4:0][7:0] port_pin_val;
    logic [4:0][7:0] port_rmw_val;

    ////////////////////////////////////////////////////////////////////
    // Word to operation class
    function automatic pcr_dec_t pcr_decode(input pcr_fetch_t f);
        pcr_dec_t d;
        d.valid = f.valid;
        d.fr = f.word[4:0];
        d.bitn = f.word[7:5];
        d.lit = f.word[8:0];
        d.op = OP_NOP;
        if (f.word[11:9] == `PCR_OP_JMP)
            d.op = OP_JMP;
        else if (f.word[11:8] == `PCR_OP_BCLR)
            d.op = OP_BCLR;
        else if (f.word[11:8] == `PCR_OP_BSET)
            d.op = OP_BSET;
        else if (f.word[11:8] == `PCR_OP_MOVLW)
            d.op = OP_MOVLW;
        else if (f.word[11:8] == `PCR_OP_XORLW)
            d.op = OP_XORLW;
        else if (f.word[11:5] == `PCR_OP_MOVWF)
            d.op = OP_MOVWF;
        else if (f.word[11:5] == `PCR_OP_DEC)
            d.op = OP_DEC;
        else if (f.word[11:5] == `PCR_OP_XORWF)
            d.op = OP_XORWF;
        else if (f.word[11:5] == `PCR_OP_XORFW)
            d.op = OP_XORFW;
        else if (f.word[11:5] == `PCR_OP_MOVFW)
            d.op = OP_MOVFW;
        else if (f.word[11:5] == `PCR_OP_TEST)
            d.op = OP_TEST;
        else if (f.word[11:5] == `PCR_OP_SWAP)
            d.op = OP_SWAP;
        return d;
    endfunction : pcr_decode

    // Bank-select bit, bank pointer and index to a location
    function automatic pcr_loc_t pcr_locate(input logic sel,
                                            input logic [7:0] ptr,
                                            input logic [3:0] idx,
                                            input logic direct);
        pcr_loc_t l;
        logic [3:0] bank;
        bank = LARGE_VARIANT ? ptr[7:4] : {1'b0, ptr[7:5]};
        l.is_bank = sel;
        l.blocked = sel && direct && LARGE_VARIANT
            && (bank == 4'h0);
        l.ram_idx = {bank, idx};
        l.gidx = idx;
        return l;
    endfunction : pcr_locate

    ////////////////////////////////////////////////////////////////////
    // Fetch, decode and execute advance together each clock
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pc_ff <= `PCR_RST_PC;
            dec_ff <= '0;
            ex_ff <= '0;
            hold_ff <= `PCR_RST_HOLD;
        end
        else if (jump_take)
        begin
            // Discard the two words already in flight
            pc_ff <= jump_target;
            dec_ff.valid <= 1'b0;
            ex_ff.valid <= 1'b0;
            hold_ff <= `PCR_FLUSH_HOLD;
        end
        else if (hold_ff != `PCR_RST_HOLD)
        begin
            // Extra bubble so the change costs three cycles in all
            hold_ff <= hold_ff - 2'h1;
            dec_ff.valid <= 1'b0;
            ex_ff <= pcr_decode(dec_ff);
        end
        else
        begin
            pc_ff <= pc_ff + 11'h001;
            dec_ff <= '{valid: 1'b1, word: prog_word};
            ex_ff <= pcr_decode(dec_ff);
        end
    end

    // Completion pulse, one per executed instruction
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            retire_ff <= 1'b0;
        else
            retire_ff <= ex_ff.valid;
    end

    assign prog_addr = pc_ff;
    assign retire = retire_ff;

    ////////////////////////////////////////////////////////////////////
    // Operand location; location 0 goes through the bank pointer
    assign indirect = (ex_ff.fr == 5'h00);
    assign loc = indirect
        ? pcr_locate(LARGE_VARIANT ? (bptr_ff[7:4] != 4'h0)
                                   : bptr_ff[`PCR_FR_BANK_BIT],
                     bptr_ff, bptr_ff[3:0], 1'b0)
        : pcr_locate(ex_ff.fr[`PCR_FR_BANK_BIT], bptr_ff,
                     ex_ff.fr[3:0], 1'b1);

    assign rmw = ex_ff.op inside {OP_DEC, OP_XORFW, OP_SWAP,
                                  OP_BCLR, OP_BSET};

    // Operand read
    always_comb
    begin
        rd_val = `PCR_RST_BYTE;
        if (loc.blocked)
            rd_val = `PCR_RST_BYTE;
        else if (loc.is_bank)
            rd_val = bank_ram_ff[loc.ram_idx];
        else if (loc.gidx == `PCR_ADDR_DEREF)
            rd_val = `PCR_RST_BYTE;
        else if (loc.gidx == `PCR_ADDR_CNTW)
            rd_val = counter_alias_select ? tick_ff : w_ff;
        else if (loc.gidx == `PCR_ADDR_PCL)
            rd_val = pc_ff[7:0];
        else if (loc.gidx == `PCR_ADDR_STATUS)
            rd_val = status_ff;
        else if (loc.gidx == `PCR_ADDR_BANKPTR)
            rd_val = bptr_ff;
        else if (loc.gidx >= `PCR_ADDR_PORTA && loc.gidx < PORT_END)
            rd_val = rmw ? port_rmw_val[3'(loc.gidx - `PCR_ADDR_PORTA)]
                         : port_pin_val[3'(loc.gidx - `PCR_ADDR_PORTA)];
        else
            rd_val = glob_ram_ff[loc.gidx];
    end

    assign bmask = 8'(8'h01 << ex_ff.bitn);

    // Result and destination per operation class
    always_comb
    begin
        res = rd_val;
        wr_f = 1'b0;
        wr_w = 1'b0;
        nxt_w = w_ff;
        case (ex_ff.op)
            OP_MOVWF:
            begin
                res = w_ff;
                wr_f = 1'b1;
            end
            OP_MOVFW:
            begin
                nxt_w = rd_val;
                wr_w = 1'b1;
            end
            OP_DEC:
            begin
                res = rd_val - 8'h01;
                wr_f = 1'b1;
            end
            OP_XORFW:
            begin
                res = rd_val ^ w_ff;
                wr_f = 1'b1;
            end
            OP_XORWF:
            begin
                nxt_w = rd_val ^ w_ff;
                wr_w = 1'b1;
            end
            OP_SWAP:
            begin
                res = {rd_val[3:0], rd_val[7:4]};
                wr_f = 1'b1;
            end
            OP_BCLR:
            begin
                res = rd_val & ~bmask;
                wr_f = 1'b1;
            end
            OP_BSET:
            begin
                res = rd_val | bmask;
                wr_f = 1'b1;
            end
            OP_MOVLW:
            begin
                nxt_w = ex_ff.lit[7:0];
                wr_w = 1'b1;
            end
            OP_XORLW:
            begin
                nxt_w = w_ff ^ ex_ff.lit[7:0];
                wr_w = 1'b1;
            end
            default:
            begin
                res = rd_val;
            end
        endcase
    end

    // Write decode; blocked locations swallow the write
    assign f_wr = ex_ff.valid && wr_f && !loc.blocked;
    assign g_wr = f_wr && !loc.is_bank;
    assign pc_wr = g_wr && (loc.gidx == `PCR_ADDR_PCL);
    assign jump_take = ex_ff.valid
        && ((ex_ff.op == OP_JMP) || pc_wr);
    assign jump_target = pc_wr
        ? {status_ff[`PCR_STATUS_PA_HI:`PCR_STATUS_PA_LO], 1'b0, res}
        : {status_ff[`PCR_STATUS_PA_HI:`PCR_STATUS_PA_LO],
           ex_ff.lit};

    ////////////////////////////////////////////////////////////////////
    // Working register, also written through location 1
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            w_ff <= `PCR_RST_BYTE;
        else if (ex_ff.valid && wr_w)
            w_ff <= nxt_w;
        else if (g_wr && loc.gidx == `PCR_ADDR_CNTW
                 && !counter_alias_select)
            w_ff <= res;
    end

    // Free-running counter; a write through location 1 wins
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            tick_ff <= `PCR_RST_BYTE;
        else if (g_wr && loc.gidx == `PCR_ADDR_CNTW
                 && counter_alias_select)
            tick_ff <= res;
        else
            tick_ff <= tick_ff + 8'h01;
    end

    // Status and bank pointer
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status_ff <= `PCR_RST_BYTE;
            bptr_ff <= `PCR_RST_BYTE;
        end
        else
        begin
            if (g_wr && loc.gidx == `PCR_ADDR_STATUS)
                status_ff <= res;
            if (g_wr && loc.gidx == `PCR_ADDR_BANKPTR)
                bptr_ff <= res;
        end
    end

    // Global RAM, including unfitted port locations; data not reset
    always_ff @(posedge clk)
    begin
        if (g_wr && loc.gidx > `PCR_ADDR_BANKPTR
            && !(loc.gidx >= `PCR_ADDR_PORTA && loc.gidx < PORT_END))
            glob_ram_ff[loc.gidx] <= res;
    end

    // Banked RAM; the small variant only touches the lower half
    always_ff @(posedge clk)
    begin
        if (f_wr && loc.is_bank)
            bank_ram_ff[loc.ram_idx] <= res;
    end

    ////////////////////////////////////////////////////////////////////
    // Port slices; unfitted ones never drive and never get writes
    for (genvar i = 0; i < 5; i++)
    begin : g_port
        assign port_wr[i] = g_wr && (i < PORTS_PRESENT)
            && (loc.gidx == 4'(`PCR_ADDR_PORTA + i));
        pcr_port #(
            .PRESENT(i < PORTS_PRESENT)
        ) u_port (
            .clk(clk),
            .arst_n(arst_n),
            .pin_in(port_pin_in[i]),
            .drive_en(port_drive_en[i]),
            .wr_en(port_wr[i]),
            .wr_data(res),
            .pin_val(port_pin_val[i]),
            .rmw_val(port_rmw_val[i]),
            .pins(port_pins[i])
        );
    end

endmodule : pcr_core

//--- tb/pcr_core_asserts.sv
// Checker for the core: pipeline timing and port drive relations.
// Assumes it is bound into pcr_core and sees only its ports.
module pcr_core_asserts
#(
    parameter int PORTS_PRESENT = 5 // Ports fitted
)
(
    input wire logic clk, // Core clock
    input wire logic arst_n, // Async reset, active low
    input wire logic [10:0] prog_addr, // Fetch address
    input wire logic [4:0][7:0] port_drive_en, // Drive enables
    input wire pcr_pkg::pcr_pins_t [4:0] port_pins, // Pin drive
    input wire logic retire // Completion pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    import pcr_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
////////////////////////////////////////////////////////////
    // Reset release: three fill cycles, then the first completion
    property p_fill;
        $rose(arst_n) |-> prog_addr == 11'h000 && !retire
            ##1 prog_addr == 11'h001 && !retire
            ##1 prog_addr == 11'h002 && !retire ##1 retire;
    endproperty
    a_fill: assert property (p_fill)
        else $error("pipeline fill timing wrong");
    // Three plain fetch steps leave nothing flushed: one completes
    property p_rate;
        $past(prog_addr) == 11'($past(prog_addr, 2) + 1)
        && $past(prog_addr, 2) == 11'($past(prog_addr, 3) + 1)
        && $past(prog_addr, 3) == 11'($past(prog_addr, 4) + 1)
        |-> retire;
    endproperty
    a_rate: assert property (p_rate)
        else $error("full pipeline missed a completion");
    // A taken jump: its own completion, three empty cycles, refill
    property p_flush;
        $past(prog_addr) == 11'($past(prog_addr, 2) + 1)
        && prog_addr != 11'($past(prog_addr) + 1)
        |-> retire ##1 !retire [*3] ##1 retire;
    endproperty
    a_flush: assert property (p_flush)
        else $error("jump penalty not three cycles");
    // Target address stands two cycles, then fetch resumes in order
    property p_hold;
        $past(prog_addr) == 11'($past(prog_addr, 2) + 1)
        && prog_addr != 11'($past(prog_addr) + 1)
        |=> $stable(prog_addr) ##1 prog_addr == 11'($past(prog_addr) + 1);
    endproperty
    a_hold: assert property (p_hold)
        else $error("refill after jump out of order");
    // Latches only move when an instruction completes
    property p_dout_a;
        !$stable(port_pins[0].dout) |-> retire;
    endproperty
    a_dout_a: assert property (p_dout_a)
        else $error("port a latch moved without an instruction");
    property p_dout_b;
        !$stable(port_pins[1].dout) |-> retire;
    endproperty
    a_dout_b: assert property (p_dout_b)
        else $error("port b latch moved without an instruction");
    // Drive follows its enable one edge late
    property p_oe;
        $past(arst_n) |-> port_pins[0].oe_n == ~$past(port_drive_en[0]);
    endproperty
    a_oe: assert property (p_oe)
        else $error("port a drive does not follow its enable");
    // An unfitted port never drives, whatever its enables say
    property p_unfit;
        PORTS_PRESENT < 4 |-> port_pins[3].oe_n == 8'hFF
            && port_pins[3].dout == 8'h00;
    endproperty
    a_unfit: assert property (p_unfit)
        else $error("unfitted port d is driving");
endmodule : pcr_core_asserts

bind pcr_core pcr_core_asserts #(.PORTS_PRESENT(PORTS_PRESENT))
    pcr_core_asserts_inst
(
    .clk(clk),
    .arst_n(arst_n),
    .prog_addr(prog_addr),
    .port_drive_en(port_drive_en),
    .port_pins(port_pins),
    .retire(retire)
);

//--- tb/pcr_prog_rom.sv
// Program memory model: one word per address, same cycle.
// Assumes the bench fills mem while the core is held in reset.
module pcr_prog_rom
(
    input wire logic [10:0] prog_addr, // Fetch address
    output logic [11:0] prog_word // Word at that address
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] mem [0:2047];
    // Plain array read; the core samples it at the fetch edge
    assign prog_word = mem[prog_addr];
endmodule : pcr_prog_rom

//--- tb/testbench.sv
// Bench: runs short programs on the core and compares port latches.
// Assumes the checker is bound to the core and the package compiled.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pcr_pkg::*;
    localparam logic [6:0] TO_F = 7'h01; // Store W into fr
    localparam logic [6:0] FROM_F = 7'h10; // Load W from fr
    localparam logic [6:0] XOR_WF = 7'h0C; // W ^= fr
    localparam logic [6:0] SWAP_F = 7'h1D; // Swap nibbles of fr
    localparam logic [3:0] LIT_W = 4'hC; // Load W with literal
    localparam logic [3:0] JUMP = 4'hA; // Jump below 0x100
    localparam logic [3:0] BIT_SET = 4'h5; // Set one bit
    localparam logic [3:0] BIT_CLR = 4'h4; // Clear one bit
    localparam logic [11:0] NOP = 12'h000; // No-operation
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [10:0] prog_addr;
    logic [11:0] prog_word;
    logic counter_alias_select = 1'b0;
    logic [4:0][7:0] port_drive_en = '0;
    logic [4:0][7:0] port_pin_in = '0;
    logic [4:0][7:0] ext_lvl = '0; // Levels from outside
    logic [4:0][7:0] ext_hold = '0; // Pins overpowered outside
    pcr_pins_t [4:0] port_pins;
    logic retire;
    logic [11:0] prog [$];
    logic [7:0] r0, r1, r2, r3;
    int mismatches = 0;
    int num_checks = 0;
    int seed = 77;
////////////////////////////////////////////////////////////
    always #2 clk = ~clk;
    // Pin level: latch where driven, unless held from outside
    always @(posedge clk)
    begin
        for (int i = 0; i < 5; i++)
        begin
            port_pin_in[i] <= (~port_pins[i].oe_n & ~ext_hold[i]
                & port_pins[i].dout) | ((port_pins[i].oe_n | ext_hold[i])
                & ext_lvl[i]);
        end
    end
    pcr_core #(.LARGE_VARIANT(1'b1), .PORTS_PRESENT(3)) pcr_core_inst
    (
        .clk(clk),
        .arst_n(arst_n),
        .prog_addr(prog_addr),
        .prog_word(prog_word),
        .counter_alias_select(counter_alias_select),
        .port_drive_en(port_drive_en),
        .port_pin_in(port_pin_in),
        .port_pins(port_pins),
        .retire(retire)
    );
    pcr_prog_rom pcr_prog_rom_inst
    (
        .prog_addr(prog_addr),
        .prog_word(prog_word)
    );
////////////////////////////////////////////////////////////
    function automatic logic [11:0] wf(input logic [6:0] op,
        input logic [4:0] fr);
        return {op, fr};
    endfunction : wf
    function automatic logic [11:0] wk(input logic [3:0] op,
        input logic [7:0] k);
        return {op, k};
    endfunction : wk
    // Latch after set 0, set 1, nop, clear 0: driven bits keep edits
    function automatic logic [7:0] exp_rmw(input logic [7:0] ext,
        input logic [7:0] drv);
        return ((ext & ~drv) | (drv & 8'h03)) & 8'hFE;
    endfunction : exp_rmw
    // Port driven all high; held bits read the outside level
    function automatic logic [7:0] exp_pin(input logic [7:0] ext,
        input logic [7:0] hold);
        return ~hold | (ext & hold);
    endfunction : exp_pin
    task automatic check(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        if (mismatches == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // Loads the program and a closing self jump, resets, runs it
    task automatic run();
        logic [7:0] last;
        last = 8'(prog.size());
        prog.push_back(wk(JUMP, last));
        arst_n <= 1'b0;
        for (int i = 0; i < 2048; i++)
        begin
            pcr_prog_rom_inst.mem[i] = (i < prog.size()) ? prog[i] : NOP;
        end
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        for (int n = 0; n < 300 && prog_addr !== 11'(last); n++)
        begin
            @(negedge clk);
        end
        repeat (4) @(posedge clk);
    endtask : run
////////////////////////////////////////////////////////////
    // Watchdog: far beyond the few hundred cycles the runs need
    initial
    begin
        #40000;
        mismatches++;
        end_of_test();
    end
    initial
    begin
        // Banks, deref, global RAM, unfitted port, working alias
        repeat (3)
        begin
            r0 = 8'($random(seed));
            r1 = 8'($random(seed));
            r2 = 8'($random(seed));
            r3 = 8'($random(seed));
            port_drive_en <= {8'($random(seed)), 8'($random(seed)),
                24'hFFFFFF};
            ext_hold <= '0;
            prog = {wk(LIT_W, 8'h20), wf(TO_F, 5'h04), wk(LIT_W, r0),
                wf(TO_F, 5'h13), wk(LIT_W, r1), wf(TO_F, 5'h08),
                wk(LIT_W, r2), wf(TO_F, 5'h0A), wk(LIT_W, 8'h30),
                wf(TO_F, 5'h04), wk(LIT_W, r3), wf(TO_F, 5'h13),
                wf(FROM_F, 5'h13), wf(TO_F, 5'h05), wk(LIT_W, 8'h23),
                wf(TO_F, 5'h04), wf(FROM_F, 5'h00), wf(TO_F, 5'h06),
                wk(LIT_W, 8'h0A), wf(TO_F, 5'h04), wf(FROM_F, 5'h08),
                wf(XOR_WF, 5'h00), wf(TO_F, 5'h07), wk(LIT_W, 8'h05),
                wf(TO_F, 5'h04), wk(LIT_W, 8'hFF), wf(TO_F, 5'h13),
                wf(FROM_F, 5'h13), wf(XOR_WF, 5'h05), wf(TO_F, 5'h05),
                wf(FROM_F, 5'h06), wf(SWAP_F, 5'h01), wf(TO_F, 5'h06)};
            run();
            check("port a", port_pins[0].dout, r3);
            check("port b", port_pins[1].dout, {r0[3:0], r0[7:4]});
            check("port c", port_pins[2].dout, r1 ^ r2);
        end
        // Jump and counter write: words behind them must not land
        prog = {wk(LIT_W, 8'h11), wf(TO_F, 5'h05), wk(JUMP, 8'h07),
            wk(LIT_W, 8'hEE), wf(TO_F, 5'h05), wk(LIT_W, 8'hEE),
            wf(TO_F, 5'h05), wk(LIT_W, 8'h0E), wf(TO_F, 5'h02),
            wk(LIT_W, 8'hEE), wf(TO_F, 5'h06), wf(TO_F, 5'h05),
            wf(TO_F, 5'h05), wf(TO_F, 5'h06), wk(LIT_W, 8'h22),
            wf(TO_F, 5'h06), wk(LIT_W, 8'h40), wf(TO_F, 5'h01),
            wk(LIT_W, 8'h00), wf(FROM_F, 5'h01), wf(TO_F, 5'h07)};
        counter_alias_select <= 1'b1;
        run();
        check("flushed port a", port_pins[0].dout, 8'h11);
        check("counter write port b", port_pins[1].dout, 8'h22);
        check("counter c", port_pins[2].dout, 8'h41);
        // Back-to-back bit edits and pins held against the latch
        repeat (3)
        begin
            r0 = 8'($random(seed));
            r1 = 8'($random(seed));
            r2 = 8'($random(seed));
            r3 = 8'($random(seed));
            port_drive_en <= {8'($random(seed)), 8'($random(seed)),
                8'hFF, r1, 8'hFF};
            ext_lvl <= {24'h000000, r0, r3};
            ext_hold <= {32'h00000000, r2};
            prog = {wk(LIT_W, 8'hFF), wf(TO_F, 5'h05), NOP, NOP,
                wk(BIT_SET, {3'd0, 5'h06}), wk(BIT_SET, {3'd1, 5'h06}),
                NOP,
                wk(BIT_CLR, {3'd0, 5'h06}), NOP, NOP, NOP,
                wf(FROM_F, 5'h05), wf(TO_F, 5'h07)};
            run();
            check("edited port b", port_pins[1].dout, exp_rmw(r0, r1));
            check("pins into c", port_pins[2].dout, exp_pin(r3, r2));
            check("latch a", port_pins[0].dout, 8'hFF);
        end
        end_of_test();
    end
endmodule : testbench
